// ### eeprom_pkg.sv
package eeprom_pkg;

  // array geometry
  localparam int          ADDR_W      = 15;
  localparam int          MEM_DEPTH   = 32768;
  localparam int          PAGE_W      = 6;
  localparam int          PAGE_BYTES  = 64;
  localparam int          STRAP_W     = 3;

  // device address word layout
  localparam logic [3:0]  TYPE_CODE   = 4'hA;
  localparam int          TYPE_MSB    = 7;
  localparam int          TYPE_LSB    = 4;
  localparam int          SEL_MSB     = 3;
  localparam int          SEL_LSB     = 1;
  localparam int          RW_BIT      = 0;
  localparam logic        RW_READ     = 1'b1;

  // bit counts on the wire
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT = 4'h7;

  // self timed write: longest time rounds down to whole cycles
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          TWC_NS        = 5000000;
  localparam int          WC_CLKS       = TWC_NS / CLK_PERIOD_NS;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 15'h0000;
  localparam logic [7:0]        BYTE_RST  = 8'h00;

  // pin pair as it travels after synchronising
  typedef struct packed {
    logic scl;
    logic sda;
  } line_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_RX   = 3'b001,
    PH_ACK  = 3'b010,
    PH_TX   = 3'b011,
    PH_RACK = 3'b100,
    PH_WAIT = 3'b101
  } phase_type;

  typedef enum logic [1:0] {
    K_DEV  = 2'b00,
    K_AHI  = 2'b01,
    K_ALO  = 2'b10,
    K_DATA = 2'b11
  } kind_type;

endpackage : eeprom_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
// two flop synchroniser for asynchronous pins
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // raw pins and their synchronised copies
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pin_sync

// ### byte_store.sv
`timescale 1ns/1ps
// flip-flop byte array, one write and one read port
module byte_store #(
  parameter int AW    = 15,
  parameter int DEPTH = 32768
) (
  // clock
  input  wire logic          sys_clk_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);

  logic [7:0] mem_q [DEPTH];

  // contents are not reset, like a real array after power up
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];

endmodule : byte_store

// ### eeprom_slave.sv
// Contract
// - sample data on clock rise, shift out on fall; clock at most 400 kHz.
// - data line open drain, changes only while clock low except start/stop.
// - data fall with clock high is a start; it opens every transaction.
// - data rise with clock high is a stop; after reads it means standby.
// - stop after write data starts the self timed write, then standby.
// - self timed write ends within 5 ms of its stop.
// - bytes of eight bits; receiver acks low on ninth clock, sender releases.
// - after a read byte release; ack reads on, nack plus stop idles.
// - first byte is type 1010, selects A2 A1 A0, then direction.
// - direction 1 is read, 0 is write.
// - matching address byte is acked; mismatch returns to standby.
// - up to eight devices; an open select strap counts as low; the code compares straps as sampled, with no pull.
// - byte write: address, two offset bytes, data, stop; busy ignores bus.
// - page write bumps low six offset bits, wrapping within 64 bytes.
// - protect high: ack address bytes, nack first data byte, no write.
// - protect low allows writes everywhere; reads never depend on protect.
// - while busy a write address byte gets nack, afterwards an ack.
// - counter holds last address plus one; reads return it msb first.
// - reads wrap at array end to zero; writes wrap within the page.
// - counter undefined at power up; controller sets it before relying.
// - random read: dummy write of offset, repeated start, read from it.
// - sequential reads wrap from last address to zero and continue.
`timescale 1ns/1ps
module eeprom_slave #(
  parameter int WC_CLKS = eeprom_pkg::WC_CLKS
) (
  // clock and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_i,
  // two wire bus
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_o,
  // straps
  input  wire logic                            write_protect_i,
  input  wire logic [eeprom_pkg::STRAP_W-1:0]  device_select_straps_i,
  // status
  output logic                                 write_busy_o
);

  typedef struct packed {
    eeprom_pkg::phase_type                               phase;
    eeprom_pkg::kind_type                                kind;
    logic [3:0]                                          cnt;
    logic [7:0]                                          shift;
    logic                                                rw;
    logic                                                drive;
    logic                                                go_on;
    logic [eeprom_pkg::ADDR_W-1:0]                       addr;
    logic [eeprom_pkg::PAGE_BYTES-1:0]                   mask;
    logic [eeprom_pkg::PAGE_BYTES-1:0][7:0]              page;
    logic                                                busy;
    logic [eeprom_pkg::PAGE_W:0]                         cidx;
    logic [31:0]                                         timer;
    eeprom_pkg::line_type                                prev;
  } state_type;

  localparam logic [31:0] WC_LAST = 32'(WC_CLKS - 1);

  state_type                            s_q;
  state_type                            s_d;
  eeprom_pkg::line_type                 line_s;
  logic [eeprom_pkg::STRAP_W:0]         strap_s;
  logic [7:0]                           rdata;
  logic                                 mem_we;
  logic [eeprom_pkg::ADDR_W-1:0]        mem_waddr;
  logic                                 scl_rise;
  logic                                 scl_fall;
  logic                                 start_seen;
  logic                                 stop_seen;

  // pins enter through two flops before any logic looks at them
  pin_sync #(
    .W (2)
  ) u_line_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({scl_i, sda_i}),
    .sync_o    (line_s)
  );

  pin_sync #(
    .W (eeprom_pkg::STRAP_W + 1)
  ) u_strap_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({write_protect_i, device_select_straps_i}),
    .sync_o    (strap_s)
  );

  byte_store #(
    .AW    (eeprom_pkg::ADDR_W),
    .DEPTH (eeprom_pkg::MEM_DEPTH)
  ) u_store (
    .sys_clk_i (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (s_q.page[s_q.cidx[eeprom_pkg::PAGE_W-1:0]]),
    .raddr_i   (s_q.addr),
    .rdata_o   (rdata)
  );

  // edges of the synchronised pins; prev is the next flop down the chain
  assign scl_rise   = line_s.scl & ~s_q.prev.scl;
  assign scl_fall   = ~line_s.scl & s_q.prev.scl;
  assign start_seen = line_s.scl & s_q.prev.scl & s_q.prev.sda & ~line_s.sda;
  assign stop_seen  = line_s.scl & s_q.prev.scl & ~s_q.prev.sda & line_s.sda;

  // commit one page byte per clock during the write cycle
  assign mem_we    = s_q.busy & ~s_q.cidx[eeprom_pkg::PAGE_W]
                     & s_q.mask[s_q.cidx[eeprom_pkg::PAGE_W-1:0]];
  assign mem_waddr = {s_q.addr[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
                      s_q.cidx[eeprom_pkg::PAGE_W-1:0]};

  // address byte decode: type code and straps; straps are compared as sampled, nothing pulls an open one low
  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [eeprom_pkg::STRAP_W-1:0] sel);
    addr_match = (b[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB] == eeprom_pkg::TYPE_CODE)
                 && (b[eeprom_pkg::SEL_MSB:eeprom_pkg::SEL_LSB] == sel);
  endfunction : addr_match

  always_comb
  begin
    s_d      = s_q;
    s_d.prev = line_s;
    if (s_q.busy)
    begin
      // bus ignored entirely, so polls see no ack until the write is done
      s_d.drive = 1'b0;
      s_d.phase = eeprom_pkg::PH_IDLE;
      if (!s_q.cidx[eeprom_pkg::PAGE_W])
      begin
        s_d.cidx = s_q.cidx + 7'h01;
      end
      s_d.timer = s_q.timer + 32'h0000_0001;
      if (s_q.timer >= WC_LAST && s_q.cidx[eeprom_pkg::PAGE_W])
      begin
        s_d.busy = 1'b0;
        s_d.mask = '0;
      end
    end
    else if (start_seen)
    begin
      // any start aborts the byte; a pending page is dropped, not written
      s_d.phase = eeprom_pkg::PH_RX;
      s_d.kind  = eeprom_pkg::K_DEV;
      s_d.cnt   = 4'h0;
      s_d.drive = 1'b0;
      s_d.mask  = '0;
    end
    else if (stop_seen)
    begin
      s_d.phase = eeprom_pkg::PH_IDLE;
      s_d.drive = 1'b0;
      if (|s_q.mask)
      begin
        s_d.busy  = 1'b1;
        s_d.cidx  = '0;
        s_d.timer = '0;
      end
    end
    else
    begin
      unique case (s_q.phase)
        eeprom_pkg::PH_IDLE,
        eeprom_pkg::PH_WAIT:
        begin
          s_d.drive = 1'b0;
        end
        eeprom_pkg::PH_RX:
        begin
          if (scl_rise)
          begin
            s_d.shift = {s_q.shift[6:0], line_s.sda};
            s_d.cnt   = s_q.cnt + 4'h1;
          end
          else if (scl_fall && s_q.cnt == eeprom_pkg::BITS_BYTE)
          begin
            s_d.cnt   = 4'h0;
            s_d.phase = eeprom_pkg::PH_ACK;
            s_d.drive = 1'b1;
            unique case (s_q.kind)
              eeprom_pkg::K_DEV:
              begin
                if (addr_match(s_q.shift, strap_s[eeprom_pkg::STRAP_W-1:0]))
                begin
                  s_d.rw   = (s_q.shift[eeprom_pkg::RW_BIT] == eeprom_pkg::RW_READ);
                  s_d.kind = eeprom_pkg::K_AHI;
                end
                else
                begin
                  s_d.phase = eeprom_pkg::PH_IDLE;
                  s_d.drive = 1'b0;
                end
              end
              eeprom_pkg::K_AHI:
              begin
                // top received bit lies beyond the array and is dropped
                s_d.addr[eeprom_pkg::ADDR_W-1:8] = s_q.shift[6:0];
                s_d.kind = eeprom_pkg::K_ALO;
              end
              eeprom_pkg::K_ALO:
              begin
                s_d.addr[7:0] = s_q.shift;
                s_d.kind      = eeprom_pkg::K_DATA;
              end
              eeprom_pkg::K_DATA:
              begin
                if (strap_s[eeprom_pkg::STRAP_W])
                begin
                  // protected: no ack, nothing buffered, no write cycle
                  s_d.phase = eeprom_pkg::PH_WAIT;
                  s_d.drive = 1'b0;
                  s_d.mask  = '0;
                end
                else
                begin
                  s_d.page[s_q.addr[eeprom_pkg::PAGE_W-1:0]] = s_q.shift;
                  s_d.mask[s_q.addr[eeprom_pkg::PAGE_W-1:0]] = 1'b1;
                  s_d.addr[eeprom_pkg::PAGE_W-1:0] =
                    s_q.addr[eeprom_pkg::PAGE_W-1:0] + 6'h01;
                end
              end
            endcase
          end
        end
        eeprom_pkg::PH_ACK:
        begin
          if (scl_fall)
          begin
            s_d.drive = 1'b0;
            if (s_q.rw && s_q.kind == eeprom_pkg::K_AHI)
            begin
              // read straight from the counter after the address ack
              s_d.phase = eeprom_pkg::PH_TX;
              s_d.shift = rdata;
              s_d.drive = ~rdata[7];
              s_d.addr  = s_q.addr + 15'h0001;
            end
            else
            begin
              s_d.phase = eeprom_pkg::PH_RX;
            end
          end
        end
        eeprom_pkg::PH_TX:
        begin
          if (scl_fall)
          begin
            if (s_q.cnt == eeprom_pkg::LAST_TX_BIT)
            begin
              s_d.drive = 1'b0;
              s_d.phase = eeprom_pkg::PH_RACK;
            end
            else
            begin
              s_d.cnt   = s_q.cnt + 4'h1;
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.drive = ~s_q.shift[6];
            end
          end
        end
        eeprom_pkg::PH_RACK:
        begin
          if (scl_rise)
          begin
            s_d.go_on = ~line_s.sda;
          end
          else if (scl_fall)
          begin
            if (s_q.go_on)
            begin
              // counter wraps from the last address to zero
              s_d.phase = eeprom_pkg::PH_TX;
              s_d.cnt   = 4'h0;
              s_d.shift = rdata;
              s_d.drive = ~rdata[7];
              s_d.addr  = s_q.addr + 15'h0001;
            end
            else
            begin
              s_d.phase = eeprom_pkg::PH_WAIT;
            end
          end
        end
        default:
        begin
          s_d.phase = eeprom_pkg::PH_IDLE;
          s_d.drive = 1'b0;
        end
      endcase
    end
  end

  // counter is left at zero on reset though software may not rely on it
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_q       <= '0;
      s_q.phase <= eeprom_pkg::PH_IDLE;
      s_q.kind  <= eeprom_pkg::K_DEV;
      s_q.addr  <= eeprom_pkg::ADDR_RST;
      s_q.shift <= eeprom_pkg::BYTE_RST;
      s_q.prev  <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // open drain: only ever pull low
  assign sda_o        = 1'b0;
  assign sda_oe_o     = s_q.drive;
  assign write_busy_o = s_q.busy;

endmodule : eeprom_slave

// ### eeprom_slave_sva.sv
`timescale 1ns/1ps
// pin-level checks on the eeprom target, bound from the bench
module eeprom_slave_checker #(
  parameter int WC_CLKS = 250000
) (
  // clock and reset
  input wire logic                           sys_clk_i,
  input wire logic                           rst_i,
  // two wire bus
  input wire logic                           scl_i,
  input wire logic                           sda_i,
  input wire logic                           sda_o,
  input wire logic                           sda_oe_o,
  // straps and status
  input wire logic                           write_protect_i,
  input wire logic [eeprom_pkg::STRAP_W-1:0] device_select_straps_i,
  input wire logic                           write_busy_o
);
  // busy lasts the timer or the page commit, whichever is longer
  localparam int WC_LEN = (WC_CLKS > eeprom_pkg::PAGE_BYTES) ? WC_CLKS
                                                              : eeprom_pkg::PAGE_BYTES + 1;
  int busy_cnt_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // length of the running write cycle, cleared whenever idle
  always_ff @(posedge sys_clk_i)
    busy_cnt_q <= (rst_i || !write_busy_o) ? 0 : busy_cnt_q + 1;

  // pin stays open drain, a drive change lands only in the clock low phase
  property p_open_drain; sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_change_low; $changed(sda_oe_o) |-> !$past(scl_i) && !$past(scl_i, 2); endproperty
  a_change_low: assert property (p_change_low) else $error("drive moved, clock high");
  property p_drive_holds; $rose(sda_oe_o) |-> sda_oe_o [*5]; endproperty
  a_drive_holds: assert property (p_drive_holds) else $error("drive too short");

  // write cycle: starts on a stop, runs exactly its length, keeps the bus deaf
  property p_busy_after_stop; $rose(write_busy_o) |-> scl_i && sda_i && !sda_oe_o; endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy without stop");
  property p_busy_len; $fell(write_busy_o) |-> busy_cnt_q == WC_LEN; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_busy_max; busy_cnt_q <= WC_LEN; endproperty
  a_busy_max: assert property (p_busy_max) else $error("write cycle overran");
  property p_busy_mute; write_busy_o |-> !sda_oe_o; endproperty
  a_busy_mute: assert property (p_busy_mute) else $error("ack while busy");
  property p_wp_nowrite; $rose(write_busy_o) |-> !write_protect_i; endproperty
  a_wp_nowrite: assert property (p_wp_nowrite) else $error("write while protected");

  // main scenarios seen
  c_write_cycle: cover property ($fell(write_busy_o));
  c_drive: cover property ($rose(sda_oe_o));
  c_protected: cover property (write_protect_i && $fell(sda_oe_o));
endmodule : eeprom_slave_checker

// ### bus_controller_model.sv
`timescale 1ns/1ps
// bus controller: makes the serial clock, pulls the data wire low
module bus_controller_model (
  // pace of the link
  input  wire logic        clk_i,
  // resolved data wire
  input  wire logic        sda_i,
  // link pins
  output logic             scl_o,
  output logic             sda_oe_o,
  // last byte or ack seen and a running count of them
  output logic [7:0]       res_o,
  output logic [15:0]      res_cnt_o
);
  // clock idles high and stands still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    res_o = 8'h00;
    res_cnt_o = 16'h0000;
  end

  // wait on the driving edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // data moves a clock after the fall, so no false start or stop is seen
  task automatic bit_x(input logic b, output logic r);
    tick(1);
    sda_oe_o = ~b;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_x

  // start, also used as repeated start
  task automatic start();
    tick(1);
    sda_oe_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    tick(1);
    sda_oe_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b0;
    tick(4);
  endtask : stop

  // byte out msb first, line released for the ninth clock
  task automatic send(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    res_o = {7'h00, r};
    res_cnt_o = res_cnt_o + 16'h0001;
  endtask : send

  // byte in, then our ack (0) or no-ack (1)
  task automatic recv(input logic nak);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nak, r);
    res_o = d;
    res_cnt_o = res_cnt_o + 16'h0001;
  endtask : recv
endmodule : bus_controller_model

// ### eeprom_slave_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module eeprom_slave_tb;
  localparam int WC = 200;
  logic              sys_clk, rst, wp, scl, m_oe, dut_sda, dut_oe, busy, sda;
  logic [2:0]        straps;
  logic [7:0]        res, exp_v;
  logic [15:0]       res_cnt;
  logic [31:0]       seed;
  logic [14:0]       cur, pg;
  logic [7:0]        mem [logic [14:0]];
  logic [7:0]        exp_q[$];
  logic [7:0]        wq[$];
  int                n_mismatch, comparisons;

  // pull-up on the wire, either party may pull it low
  assign sda = (dut_oe ? dut_sda : 1'b1) & ~m_oe;

  eeprom_slave #(.WC_CLKS(WC)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(dut_sda),
    .sda_oe_o(dut_oe), .write_protect_i(wp), .device_select_straps_i(straps),
    .write_busy_o(busy));
  bus_controller_model m (
    .clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe), .res_o(res),
    .res_cnt_o(res_cnt));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] rnd();
    seed = lfsr(seed);
    return seed[7:0];
  endfunction : rnd

  task automatic tally_and_finish();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // note the answer, then move the byte
  task automatic send_exp(input logic [7:0] v, input logic [7:0] ack);
    exp_q.push_back(ack);
    m.send(v);
  endtask : send_exp

  // address phase of a write; top offset bit must be dropped
  task automatic set_addr(input logic [15:0] a);
    m.start();
    send_exp({4'hA, straps, 1'b0}, 8'h00);
    send_exp(a[15:8], 8'h00);
    send_exp(a[7:0], 8'h00);
    cur = a[14:0];
  endtask : set_addr

  task automatic poll(input logic [7:0] ack);
    m.start();
    send_exp({4'hA, straps, 1'b0}, ack);
    m.stop();
  endtask : poll

  // writes wq from a; offset wraps inside the page
  task automatic page_write(input logic [15:0] a);
    set_addr(a);
    foreach (wq[i])
    begin
      send_exp(wq[i], {7'h00, wp});
      // a refused byte leaves the counter where it was
      if (!wp)
      begin
        mem[cur] = wq[i];
        cur[5:0] = cur[5:0] + 6'h01;
      end
    end
    wq.delete();
    m.stop();
    m.tick(4);
    `CHK(busy, ~wp)
    if (!wp)
    begin
      poll(8'h01);
      while (busy !== 1'b0)
        m.tick(1);
      m.tick(4);
      poll(8'h00);
    end
  endtask : page_write

  // read n bytes from a, or from the counter when cur_only is set
  task automatic read_seq(input logic [15:0] a, input int n, input logic cur_only);
    if (!cur_only)
      set_addr(a);
    m.start();
    send_exp({4'hA, straps, 1'b1}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(mem[cur]);
      m.recv(i == n - 1);
      cur = cur + 15'h0001;
    end
    m.stop();
  endtask : read_seq

  // every byte or ack the controller sees meets its note
  always @(res_cnt)
    if (res_cnt !== 16'h0000)
    begin
      exp_v = exp_q.pop_front();
      `CHK(res, exp_v)
    end

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // hang guard, far above the few thousand cycles needed
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    wp = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    seed = 32'h0001_2DFC;
    straps = seed[2:0];
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    seed = lfsr(seed);
    straps = seed[2:0];
    repeat (4) @(negedge sys_clk);
    `CHK(dut_oe, 1'b0)
    // every select code, then a wrong type code
    for (int s = 0; s < 8; s++)
    begin
      m.start();
      send_exp({4'hA, s[2:0], 1'b0}, {7'h00, s[2:0] != straps});
      m.stop();
    end
    m.start();
    send_exp({4'hB, straps, 1'b0}, 8'h01);
    m.stop();
    m.tick(4);
    `CHK(busy, 1'b0)
    // page write across the page end, then counter wrap checks
    seed = lfsr(seed);
    pg = {seed[8:0], 6'h00};
    wq = '{rnd(), rnd(), rnd(), rnd(), rnd()};
    page_write({1'b1, pg | 15'h003E});
    wq = '{rnd()};
    page_write({1'b0, pg | 15'h003F});
    read_seq(16'h0000, 1, 1'b1);
    // wrapped bytes sit at the page start, so all three reads hit written data
    read_seq({1'b0, pg}, 3, 1'b0);
    // sequential read over the array end
    wq = '{rnd()};
    page_write(16'h7FFF);
    wq = '{rnd()};
    page_write(16'h0000);
    read_seq(16'h7FFF, 2, 1'b0);
    // new strap levels mid run; a code one strap off is ignored
    seed = lfsr(seed);
    straps = straps ^ {seed[2:1], 1'b1};
    m.start();
    send_exp({4'hA, straps ^ 3'h1, 1'b0}, 8'h01);
    m.stop();
    // protected write is refused, reads still work
    wp = 1'b1;
    wq = '{rnd()};
    page_write({1'b0, pg | 15'h003E});
    read_seq({1'b0, pg | 15'h003E}, 1, 1'b0);
    wp = 1'b0;
    // repeated start drops pending data
    set_addr({1'b0, pg | 15'h003E});
    send_exp(rnd(), 8'h00);
    poll(8'h00);
    m.tick(4);
    `CHK(busy, 1'b0)
    read_seq({1'b0, pg | 15'h003E}, 1, 1'b0);
    m.tick(20);
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule : eeprom_slave_tb

bind eeprom_slave eeprom_slave_checker #(.WC_CLKS(WC_CLKS)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i),
  .device_select_straps_i(device_select_straps_i), .write_busy_o(write_busy_o));
